// ### sixteen_bit_timer_counter_control_bench.sv
// Self-checking bench for the 16-bit timer/counter block
`timescale 1ns/10ps
module sixteen_bit_timer_counter_control_bench;
	import tcc_pkg::*;
	// ==========================================================
	// Stimulus and observation
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	tcc_bus_t bus = '0;  // Register port request
	logic stop_m = 1'b0;  // Chip stop mode
	logic slow_m = 1'b0;  // Chip slow mode
	logic pss = 1'b0;  // Low-frequency prescaler source
	logic fs_tap = 1'b0;  // Slow divider tap
	logic go = 1'b0;  // Pulse train request
	logic [7:0] pcount = 8'h00;  // Pulses per train
	logic [7:0] rdata;
	logic irq;
	logic ppo;
	logic pin;
	logic busy;
	logic irq_d = 1'b0;  // Interrupt one cycle ago
	logic dbl = 1'b0;  // Interrupt seen high twice in a row
	logic [15:0] a_val;
	logic [15:0] b_val;
	logic [15:0] v;
	logic [7:0] b8;
	logic [7:0] c8;
	logic [1:0] src [4] = '{CLK_TAP_NINE, CLK_TAP_FIVE, CLK_TAP_ONE, CLK_TAP_NINE};
	int per [4] = '{2048, 128, 8, 32};  // Cycles per source tick
	int error_cnt = 0;
	int compares = 0;
	int irq_cnt = 0;
	int cyc = 0;
	int t_last = 0;
	int t_prev = 0;
	int seed = 86;
	int k;

	// ==========================================================
	// Clock, slow tap and interrupt monitor
	always #4 clk_in = ~clk_in;
	// Slow tap rises every 32 cycles
	always @(posedge clk_in) begin
		if (cyc % 16 == 15) fs_tap <= ~fs_tap;
	end
	// Counts interrupt pulses, stamps their cycle, flags long pulses
	always @(negedge clk_in) begin
		cyc = cyc + 1;
		if (irq === 1'b1) begin
			irq_cnt = irq_cnt + 1;
			t_prev = t_last;
			t_last = cyc;
			if (irq_d) dbl = 1'b1;
		end
		irq_d = (irq === 1'b1);
	end

	// ==========================================================
	// Design and pin source
	tcc_timer DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1), .bus_in(bus),
		.rdata_out(rdata), .stop_mode_in(stop_m), .slow_mode_in(slow_m),
		.prescaler_source_select_in(pss), .fs_tap_in(fs_tap), .external_input_pin_in(pin),
		.timer_match_interrupt_out(irq), .programmable_pulse_output_out(ppo));
	tcc_pin_src PIN (.clk_in(clk_in), .go_in(go), .count_in(pcount), .width_in(4'h4),
		.pin_out(pin), .busy_out(busy));

	// ==========================================================
	// Tasks
	// Compares a seen value with the expected one
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// One-cycle register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		bus <= '0;
	endtask : wr
	// One-cycle read, data taken in the following cycle only
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_in);
		bus <= '0;
		@(negedge clk_in);
		d = rdata;
	endtask : rd
	// Low byte first, then high byte
	task wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 8'h01, d[15:8]);
	endtask : wr16
	task rd16(input logic [7:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 8'h01, d[15:8]);
	endtask : rd16
	task idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask : idle
	// Bounded wait for a number of interrupts or for the pin source
	task wait_for(input int n, input int bound, input logic on_pin);
		int i;
		i = 0;
		while ((on_pin ? busy !== 1'b0 : irq_cnt < n) && i < bound) begin
			@(negedge clk_in);
			i++;
		end
		if (i >= bound) begin
			error_cnt++;
			$display("CHECK FAILED wait expected done seen timeout");
			results();
		end
	endtask : wait_for
	// Prints counts and verdict, ends the run
	task results;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_in);
		arst_n_in <= 1'b1;
		// Reset values and an unmapped place
		rd16(OFS_A_LOW, v);
		check("a reset", v, TREG_RESET);
		rd16(OFS_B_LOW, v);
		check("b reset", v, TREG_RESET);
		rd(OFS_CTRL, b8);
		check("ctrl reset", {8'h00, b8}, {8'h00, CTRL_RESET});
		rd(8'h40, b8);
		check("unmapped", {8'h00, b8}, {8'h00, READ_ZERO});
		// Low byte alone leaves A, the high byte then loads it
		wr(OFS_CTRL, 8'h08);
		wr(OFS_A_LOW, 8'h34);
		idle(20);
		rd16(OFS_A_LOW, v);
		check("a low only", v, TREG_RESET);
		wr(OFS_A_HIGH, 8'h12);
		idle(20);
		rd16(OFS_A_LOW, v);
		check("a loaded", v, 16'h1234);
		// B refused outside pulse-output mode
		wr16(OFS_B_LOW, 16'h6655);
		idle(20);
		rd16(OFS_B_LOW, v);
		check("b refused", v, TREG_RESET);
		// Pulse-output mode: B accepted, not captured, output toggles at B
		b_val = 16'h0002 + 16'($unsigned($random(seed)) % 32);
		wr(OFS_CTRL, 8'h0B);
		wr16(OFS_B_LOW, b_val);
		idle(20);
		wr(OFS_CTRL, 8'h5B);
		idle(4);
		check("out before b", {15'h0000, ppo}, 16'h0000);
		idle(int'(b_val) * 8 + 24);
		check("out after b", {15'h0000, ppo}, 16'h0001);
		rd16(OFS_B_LOW, v);
		check("b kept", v, b_val);
		wr(OFS_CTRL, 8'h0B);
		wr(OFS_CTRL, 8'h08);
		// Match period over every internal source
		for (k = 0; k < 4; k++) begin
			a_val = 16'h0002 + 16'($unsigned($random(seed)) % 4);
			pss <= (k == 3);
			wr(OFS_CTRL, {4'h0, src[k], 2'b00});
			wr16(OFS_A_LOW, a_val);
			wr(OFS_CTRL, {4'h1, src[k], 2'b00});
			irq_cnt = 0;
			wait_for(2, (int'(a_val) + 1) * per[k] * 3 + 4096, 1'b0);
			check("period", 16'(t_last - t_prev), 16'((int'(a_val) + 1) * per[k]));
		end
		// Auto capture follows the count on each tick
		pss <= 1'b0;
		wr(OFS_CTRL, 8'h08);
		wr(OFS_CTRL, 8'h58);
		idle(40);
		rd(OFS_B_LOW, b8);
		idle(6);
		rd(OFS_B_LOW, c8);
		check("capture range", {15'h0000, b8 <= a_val[7:0]}, 16'h0001);
		check("capture step", {8'h00, c8}, {8'h00, (b8 == a_val[7:0]) ? 8'h00 : b8 + 8'h01});
		// Stop mode clears the start field and halts counting
		@(posedge clk_in);
		stop_m <= 1'b1;
		@(posedge clk_in);
		stop_m <= 1'b0;
		rd(OFS_CTRL, b8);
		check("stop clears", {8'h00, b8}, 16'h0048);
		irq_cnt = 0;
		idle((int'(a_val) + 1) * 24);
		check("halted", 16'(irq_cnt), 16'h0000);
		// Slow mode gives no ticks from a fast tap
		slow_m <= 1'b1;
		wr(OFS_CTRL, 8'h04);
		wr(OFS_CTRL, 8'h14);
		irq_cnt = 0;
		idle((int'(a_val) + 1) * 256);
		check("slow no tick", 16'(irq_cnt), 16'h0000);
		wr(OFS_CTRL, 8'h04);
		slow_m <= 1'b0;
		// Event counting on rising then falling pin edges
		for (k = 0; k < 2; k++) begin
			wr(OFS_CTRL, 8'h0C);
			wr(OFS_CTRL, (k == 1) ? 8'h3C : 8'h2C);
			irq_cnt = 0;
			@(posedge clk_in);
			pcount <= a_val[7:0] + 8'h01;
			go <= 1'b1;
			@(posedge clk_in);
			go <= 1'b0;
			idle(2);
			wait_for(0, 400, 1'b1);
			idle(20);
			check("event match", 16'(irq_cnt), 16'h0001);
		end
		// Window mode with the pin idle low: closed for positive logic, open for negative
		wr(OFS_CTRL, 8'h09);
		wr(OFS_CTRL, 8'h29);
		irq_cnt = 0;
		idle((int'(a_val) + 1) * 24);
		check("window closed", 16'(irq_cnt), 16'h0000);
		wr(OFS_CTRL, 8'h09);
		wr(OFS_CTRL, 8'h39);
		irq_cnt = 0;
		wait_for(2, (int'(a_val) + 1) * 24 + 64, 1'b0);
		check("window period", 16'(t_last - t_prev), 16'((int'(a_val) + 1) * 8));
		wr(OFS_CTRL, 8'h09);
		check("irq width", {15'h0000, dbl}, 16'h0000);
		results();
	end
endmodule : sixteen_bit_timer_counter_control_bench

// ### tcc_pin_src.sv
// Pulse source model that drives the external input pin of the timer
`timescale 1ns/10ps
module tcc_pin_src (
	// Clock and command
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] count_in,
	input wire logic [3:0] width_in,
	// Pin and status
	output logic pin_out,
	output logic busy_out
);
	// ==========================================================
	// Pulse train
	// Pin idles low, actively driven by the source between trains
	initial begin
		pin_out = 1'b0;
		busy_out = 1'b0;
	end
	// Emits count_in pulses, each width_in cycles high then width_in low
	always begin
		@(posedge clk_in);
		if (go_in) begin
			busy_out <= 1'b1;
			repeat (count_in) begin
				pin_out <= 1'b1;
				repeat (width_in) @(posedge clk_in);
				pin_out <= 1'b0;
				repeat (width_in) @(posedge clk_in);
			end
			busy_out <= 1'b0;
		end
	end
endmodule : tcc_pin_src

// ### tcc_pkg.sv
// Shared constants, codes and types for the 16-bit timer/counter block
package tcc_pkg;

	// ==========================================================
	// Register offsets on the byte-wide register port
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_A_LOW = 8'h10;   // Compare A, low byte
	localparam logic [7:0] OFS_A_HIGH = 8'h11;  // Compare A, high byte
	localparam logic [7:0] OFS_B_LOW = 8'h12;   // Second B, low byte
	localparam logic [7:0] OFS_B_HIGH = 8'h13;  // Second B, high byte
	localparam logic [7:0] OFS_CTRL = 8'h26;    // Timer control register

	// ==========================================================
	// Reset values and small constants
	localparam logic [15:0] TREG_RESET = 16'hFFFF;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	// ==========================================================
	// Prescaler: free-running on the high-frequency clock
	localparam int unsigned PRE_W = 11;
	localparam logic [PRE_W-1:0] PRE_ONE = 11'h001;
	localparam logic [PRE_W-1:0] MASK_TAP_NINE = 11'h7FF;  // fc/2^11
	localparam logic [PRE_W-1:0] MASK_TAP_FIVE = 11'h07F;  // fc/2^7
	localparam logic [PRE_W-1:0] MASK_TAP_ONE = 11'h007;   // fc/2^3

	// ==========================================================
	// Field codes of the control register
	localparam logic [1:0] START_STOP = 2'h0;  // Stop and clear
	localparam logic [1:0] START_CMD = 2'h1;   // Command start
	localparam logic [1:0] START_RISE = 2'h2;  // Rising edge / positive logic
	localparam logic [1:0] START_FALL = 2'h3;  // Falling edge / negative logic
	localparam logic [1:0] CLK_TAP_NINE = 2'h0;
	localparam logic [1:0] CLK_TAP_FIVE = 2'h1;
	localparam logic [1:0] CLK_TAP_ONE = 2'h2;
	localparam logic [1:0] CLK_PIN = 2'h3;
	localparam logic [1:0] MODE_TIMER = 2'h0;  // Timer / ext trigger / event
	localparam logic [1:0] MODE_WINDOW = 2'h1;
	localparam logic [1:0] MODE_PULSE = 2'h2;
	localparam logic [1:0] MODE_PPG = 2'h3;

	// ==========================================================
	// Types
	typedef struct packed {
		logic output_flipflop_control;  // Bit 7
		logic aux;                      // Bit 6: capture / trigger / shot
		logic [1:0] start_control;      // Bits 5:4
		logic [1:0] source_clock_select;  // Bits 3:2
		logic [1:0] operating_mode_select;  // Bits 1:0
	} tcc_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} tcc_bus_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ARMED = 3'h2,
		ST_RUN = 3'h4
	} tcc_state_t;

	typedef struct packed {
		tcc_state_t state;
		tcc_ctrl_t ctrl;
		logic [15:0] cnt;
		logic [15:0] a_act;
		logic [15:0] a_stage;
		logic a_pend;
		logic [15:0] b_act;
		logic [15:0] b_stage;
		logic b_pend;
		logic [PRE_W-1:0] pre;
		logic fs_s1;
		logic fs_s2;
		logic fs_prev;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic irq;
		logic ff;
		logic [7:0] rdata;
	} tcc_regs_t;

endpackage : tcc_pkg

// ### tcc_timer.sv
// 16-bit up-counting timer/counter with compare, capture and pulse output
`timescale 1ns/10ps
module tcc_timer (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	// Register port
	input wire tcc_pkg::tcc_bus_t bus_in,
	output logic [7:0] rdata_out,
	// Chip operating state
	input wire logic stop_mode_in,
	input wire logic slow_mode_in,
	input wire logic prescaler_source_select_in,
	// Asynchronous inputs
	input wire logic fs_tap_in,
	input wire logic external_input_pin_in,
	// Results
	output logic timer_match_interrupt_out,
	output logic programmable_pulse_output_out
);
	import tcc_pkg::*;

	// ==========================================================
	// State and derived signals
	tcc_regs_t s;       // Registered state
	tcc_regs_t next_s;  // Next state
	logic pin_rise;     // Synchronised pin rising edge
	logic pin_fall;     // Synchronised pin falling edge
	logic fs_rise;      // Low-frequency tap edge
	logic start_edge;   // Edge chosen by the start field
	logic opp_edge;     // The opposite edge
	logic src_tick;     // One pulse per source clock period
	logic is_event;     // Event counter: pin clock with edge start
	logic is_trig;      // External trigger: internal clock with edge start
	logic win_open;     // Window pin level that allows counting
	logic cnt_evt;      // Counter advances this cycle
	logic cap_evt;      // Auto capture this cycle

	// Prescaler tap hit for a given mask
	function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input logic [PRE_W-1:0] mask);
		tap_hit = ((pre & mask) == mask);
	endfunction : tap_hit

	// Modes in which auto capture is allowed
	function automatic logic capture_mode(input tcc_ctrl_t c, input logic trig);
		capture_mode = ((c.operating_mode_select == MODE_TIMER) && !trig) ||
			(c.operating_mode_select == MODE_WINDOW);
	endfunction : capture_mode

	// ==========================================================
	// Edge detection on synchronised inputs
	assign pin_rise = s.pin_s2 & ~s.pin_prev;
	assign pin_fall = ~s.pin_s2 & s.pin_prev;
	assign fs_rise = s.fs_s2 & ~s.fs_prev;
	assign start_edge = s.ctrl.start_control[0] ? pin_fall : pin_rise;
	assign opp_edge = s.ctrl.start_control[0] ? pin_rise : pin_fall;
	assign win_open = s.ctrl.start_control[0] ? ~s.pin_s2 : s.pin_s2;

	// Source clock selection; in slow mode the two fast taps give no tick, the slow tap and the pin still do
	always_comb begin
		case (s.ctrl.source_clock_select)
			CLK_TAP_NINE: begin
				src_tick = (slow_mode_in || prescaler_source_select_in) ? fs_rise :
					tap_hit(s.pre, MASK_TAP_NINE);
			end
			CLK_TAP_FIVE: src_tick = !slow_mode_in && tap_hit(s.pre, MASK_TAP_FIVE);
			CLK_TAP_ONE: src_tick = !slow_mode_in && tap_hit(s.pre, MASK_TAP_ONE);
			default: src_tick = pin_rise;
		endcase
	end

	// Mode decode of the shared timer/trigger/event code
	assign is_event = (s.ctrl.operating_mode_select == MODE_TIMER) &&
		s.ctrl.start_control[1] && (s.ctrl.source_clock_select == CLK_PIN);
	assign is_trig = (s.ctrl.operating_mode_select == MODE_TIMER) &&
		s.ctrl.start_control[1] && (s.ctrl.source_clock_select != CLK_PIN);

	// Counter advance: event edge, gated window tick or plain source tick
	always_comb begin
		if (s.state != ST_RUN || s.ctrl.start_control == START_STOP) begin
			cnt_evt = 1'b0;
		end else if (is_event) begin
			cnt_evt = start_edge;
		end else if (s.ctrl.operating_mode_select == MODE_WINDOW) begin
			cnt_evt = src_tick && win_open;
		end else begin
			cnt_evt = src_tick;
		end
	end

	assign cap_evt = cnt_evt && s.ctrl.aux && capture_mode(s.ctrl, is_trig);

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		next_s.irq = 1'b0;
		next_s.rdata = READ_ZERO;
		next_s.pre = s.pre + PRE_ONE;
		// Two-flop synchronisers and edge history
		next_s.fs_s1 = fs_tap_in;
		next_s.fs_s2 = s.fs_s1;
		next_s.fs_prev = s.fs_s2;
		next_s.pin_s1 = external_input_pin_in;
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_prev = s.pin_s2;

		// Staged values become active on the first source tick after the high byte
		if (src_tick && s.a_pend) begin
			next_s.a_act = s.a_stage;
			next_s.a_pend = 1'b0;
		end
		if (src_tick && s.b_pend) begin
			next_s.b_act = s.b_stage;
			next_s.b_pend = 1'b0;
		end

		// Counting per state
		case (s.state)
			ST_IDLE: begin
				next_s.cnt = CNT_ZERO;
				if (s.ctrl.start_control == START_CMD) begin
					if (s.ctrl.operating_mode_select == MODE_TIMER ||
						s.ctrl.operating_mode_select == MODE_PPG) begin
						next_s.state = ST_RUN;
					end
				end else if (s.ctrl.start_control != START_STOP) begin
					if (is_event || s.ctrl.operating_mode_select == MODE_WINDOW) begin
						next_s.state = ST_RUN;
					end else begin
						next_s.state = ST_ARMED;
					end
				end
			end
			ST_ARMED: begin
				// Wait for the trigger edge, then count from zero
				if (start_edge) begin
					next_s.state = ST_RUN;
					next_s.cnt = CNT_ZERO;
				end
			end
			ST_RUN: begin
				if (s.ctrl.operating_mode_select == MODE_PULSE) begin
					// Pulse width: capture on edges, clear per single/double setting
					if (opp_edge) begin
						next_s.b_act = s.cnt;
						next_s.irq = 1'b1;
						if (s.ctrl.aux) begin
							next_s.cnt = CNT_ZERO;
							next_s.state = ST_ARMED;
						end
					end else if (start_edge && !s.ctrl.aux) begin
						next_s.b_act = s.cnt;
						next_s.irq = 1'b1;
						next_s.cnt = CNT_ZERO;
					end else if (cnt_evt) begin
						next_s.cnt = s.cnt + CNT_ONE;
					end
				end else if (is_trig && s.ctrl.aux && opp_edge) begin
					// Trigger start and stop: opposite edge aborts quietly
					next_s.cnt = CNT_ZERO;
					next_s.state = ST_ARMED;
				end else if (cnt_evt) begin
					if (s.cnt == s.a_act) begin
						next_s.cnt = CNT_ZERO;
						next_s.irq = 1'b1;
						if (is_trig) begin
							next_s.state = ST_ARMED;
						end
						if (s.ctrl.operating_mode_select == MODE_PPG) begin
							next_s.ff = ~s.ff;
							if (s.ctrl.aux) begin
								next_s.ctrl.start_control = START_STOP;
							end
						end
					end else begin
						next_s.cnt = s.cnt + CNT_ONE;
						if (s.ctrl.operating_mode_select == MODE_PPG && s.cnt == s.b_act) begin
							next_s.ff = ~s.ff;
						end
					end
				end
			end
			default: begin
				next_s.state = ST_IDLE;
			end
		endcase

		// Auto capture copies the running count
		if (cap_evt) begin
			next_s.b_act = s.cnt;
		end

		// Stopped code clears the counter and holds the output at its set level
		if (s.ctrl.start_control == START_STOP) begin
			next_s.state = ST_IDLE;
			next_s.cnt = CNT_ZERO;
			next_s.ff = s.ctrl.output_flipflop_control;
		end

		// Register writes; pending flags set after the load so a new write wins
		if (bus_in.wr) begin
			case (bus_in.addr)
				OFS_CTRL: next_s.ctrl = tcc_ctrl_t'(bus_in.wdata);
				OFS_A_LOW: next_s.a_stage[7:0] = bus_in.wdata;
				OFS_A_HIGH: begin
					next_s.a_stage[15:8] = bus_in.wdata;
					next_s.a_pend = 1'b1;
				end
				OFS_B_LOW: begin
					if (s.ctrl.operating_mode_select == MODE_PPG) begin
						next_s.b_stage[7:0] = bus_in.wdata;
					end
				end
				OFS_B_HIGH: begin
					if (s.ctrl.operating_mode_select == MODE_PPG) begin
						next_s.b_stage[15:8] = bus_in.wdata;
						next_s.b_pend = 1'b1;
					end
				end
				default: begin
					next_s.ctrl = next_s.ctrl;
				end
			endcase
		end

		// Entering stop mode overrides any start written in the same cycle
		if (stop_mode_in) begin
			next_s.ctrl.start_control = START_STOP;
		end

		// Read data for the cycle after the strobe; unmapped reads give zero
		if (bus_in.rd) begin
			case (bus_in.addr)
				OFS_CTRL: next_s.rdata = s.ctrl;
				OFS_A_LOW: next_s.rdata = s.a_act[7:0];
				OFS_A_HIGH: next_s.rdata = s.a_act[15:8];
				OFS_B_LOW: next_s.rdata = s.b_act[7:0];
				OFS_B_HIGH: next_s.rdata = s.b_act[15:8];
				default: next_s.rdata = READ_ZERO;
			endcase
		end
	end

	// ==========================================================
	// State register; clock enable freezes everything
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s <= '0;
			s.state <= ST_IDLE;
			s.ctrl <= tcc_ctrl_t'(CTRL_RESET);
			s.a_act <= TREG_RESET;
			s.a_stage <= TREG_RESET;
			s.b_act <= TREG_RESET;
			s.b_stage <= TREG_RESET;
		end else if (clk_en_in) begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign rdata_out = s.rdata;
	assign timer_match_interrupt_out = s.irq;
	assign programmable_pulse_output_out = s.ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	a_stop_forces_code: assert property (clk_en_in && stop_mode_in |=>
		s.ctrl.start_control == START_STOP) else $error("stop mode did not stop");
	a_stopped_clears_count: assert property (clk_en_in && s.ctrl.start_control == START_STOP
		|=> s.cnt == CNT_ZERO) else $error("stopped counter not clear");
	a_match_clear_irq: assert property (clk_en_in && cnt_evt && !is_trig &&
		s.ctrl.operating_mode_select == MODE_TIMER && s.cnt == s.a_act && !stop_mode_in &&
		!bus_in.wr |=> s.irq && s.cnt == CNT_ZERO) else $error("match missed");
	a_irq_one_cycle: assert property (s.irq |=> !s.irq)
		else $error("interrupt longer than a cycle");
	a_timer_increment: assert property (clk_en_in && cnt_evt && s.cnt != s.a_act && !is_trig &&
		s.ctrl.operating_mode_select == MODE_TIMER && !bus_in.wr
		|=> s.cnt == $past(s.cnt) + CNT_ONE) else $error("count did not advance");
	a_low_byte_only: assert property (clk_en_in && !s.a_pend && bus_in.wr &&
		bus_in.addr == OFS_A_LOW |=> $stable(s.a_act)) else $error("low byte updated A");
	a_buffer_load: assert property (clk_en_in && s.a_pend && src_tick
		|=> s.a_act == $past(s.a_stage)) else $error("staged A not loaded");
	a_b_write_guard: assert property (clk_en_in && bus_in.wr && bus_in.addr == OFS_B_HIGH &&
		s.ctrl.operating_mode_select != MODE_PPG |=> $stable(s.b_stage))
		else $error("B written outside pulse mode");
	a_capture_copy: assert property (clk_en_in && cap_evt
		|=> s.b_act == $past(s.cnt)) else $error("capture missed");
	a_capture_modes: assert property (cap_evt |-> s.ctrl.operating_mode_select == MODE_TIMER ||
		s.ctrl.operating_mode_select == MODE_WINDOW) else $error("capture in wrong mode");
	a_slow_taps_dead: assert property (slow_mode_in && (s.ctrl.source_clock_select ==
		CLK_TAP_FIVE || s.ctrl.source_clock_select == CLK_TAP_ONE) |-> !src_tick)
		else $error("fast tap in slow mode");
	a_window_gate: assert property (s.ctrl.operating_mode_select == MODE_WINDOW &&
		!win_open |-> !cnt_evt) else $error("window counted while closed");

	c_match_irq: cover property (s.irq && s.ctrl.operating_mode_select == MODE_TIMER);
	c_capture: cover property (clk_en_in && cap_evt);
	c_pulse_toggle: cover property (s.ctrl.operating_mode_select == MODE_PPG && $changed(s.ff));

endmodule : tcc_timer
